/* bench/mdsrp_ctrl_model.sv */
// behavioural management controller: makes the link clock, frames traffic
module mdsrp_ctrl_model
  import mdsrp_pkg::*;
(
  // link pins
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] rx;  // wire level at each rise

  // clock stands low and line is released outside frames
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // one whole frame, msb first; reads let go from the turnaround on
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] rg, input logic [15:0] wd,
                       input logic rd, output logic [16:0] got);
    logic [63:0] tx;
    tx = {32'hffffffff, START_CODE, op, phy, rg, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      mdio_oe_o = !(rd && i < 18);
      mdio_o = tx[i];
      #200; // 2.5 MHz keeps under the ceiling
      mdc_o = 1'b1;
      rx[i] = mdio_i; // sampled on the rise
      #200;
      mdc_o = 1'b0;
    end
    mdio_oe_o = 1'b0;
    got = rx[16:0];
  endtask
endmodule

/* bench/tb.sv */
module tb
  import mdsrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RW = NUM_REGS*DW;
  logic          mclk_i;
  logic          rst_n_i;
  logic          mdc;       // link clock from the controller
  logic          dev_d;     // device drive value
  logic          dev_oe;    // device drive enable
  logic          ctl_d;     // controller drive value
  logic          ctl_oe;    // controller drive enable
  logic          wire_lvl;  // resolved line level
  logic          oe_seen;   // device drove during the frame
  logic [RW-1:0] regs;
  logic [RW-1:0] shadow;    // expected register bytes
  logic [16:0]   got;       // turnaround bit two and read data
  int            n_fail;
  int            n_compared;

  // pull-up wins when nobody drives, so a stale level never shows
  assign wire_lvl = dev_oe ? dev_d : (ctl_oe ? ctl_d : 1'b1);

  mdsrp_port u_mdsrp_port (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .mdc_i(mdc), .mdio_i(wire_lvl), .mdio_o(dev_d),
    .mdio_oe_o(dev_oe), .regs_o(regs));
  mdsrp_ctrl_model u_mdsrp_ctrl_model (.mdio_i(wire_lvl), .mdc_o(mdc),
    .mdio_o(ctl_d), .mdio_oe_o(ctl_oe));

  // 20 MHz system clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // sticky watch on the device enable
  always @(posedge mclk_i) begin
    if (dev_oe === 1'b1) oe_seen <= 1'b1;
  end

  task automatic chk(input string what, input logic [RW-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // reset held 8 cycles, registers must come back cleared
  task automatic do_reset();
    @(posedge mclk_i);
    #2 rst_n_i = 1'b0;
    repeat (8) @(posedge mclk_i);
    #2 rst_n_i = 1'b1;
    shadow = '0;
    chk("regs after reset", regs, {NUM_REGS{REG_RST}});
    chk("oe after reset", dev_oe, 1'b0);
  endtask

  // one frame, then a bounded wait for release and register settle
  task automatic xfer(input logic [1:0] op, input logic [7:0] a,
                      input logic b3, input logic [15:0] wd,
                      input logic rd);
    int i;
    @(posedge mclk_i);
    #2 oe_seen = 1'b0;
    u_mdsrp_ctrl_model.frame(op, {rd, b3, a[7:5]}, a[4:0], wd, rd, got);
    for (i = 0; i < 20 && (dev_oe !== 1'b0 || regs !== shadow); i++)
      @(posedge mclk_i);
    // a settle that never comes is a failure, and ends the run
    if (dev_oe !== 1'b0 || regs !== shadow) begin
      n_fail++;
      tally_and_finish();
    end
    #2;
  endtask

  // edge addresses, an unmapped one, both bit-three values, junk high byte
  task automatic t_cfg_rw();
    logic [7:0] a;
    logic [7:0] d;
    for (int k = 0; k < 4; k++) begin
      a = (k == 0) ? 8'h00 : (k == 1) ? 8'h8d : (k == 2) ? 8'h21 : 8'h8e;
      d = {a[3:0], ~a[7:4]};
      if (a <= LAST_REG) shadow[a*DW +: DW] = d;
      xfer(OP_CFG, a, k[0], {~d, d}, 1'b0);
      chk("regs after write", regs, shadow);
      xfer(OP_CFG, a, ~k[0], 16'hffff, 1'b1);
      chk("read data", got, {1'b0, HI_ZERO, (a <= LAST_REG) ? d : 8'h00});
      chk("line released", dev_oe, 1'b0);
    end
  endtask

  // standard and spare opcodes get no answer and store nothing
  task automatic t_other_ops();
    for (int k = 1; k < 4; k++) begin
      xfer(k[1:0], 8'h21, 1'b0, 16'h00aa, k[1]);
      chk("line never driven", oe_seen, 1'b0);
      chk("regs untouched", regs, shadow);
    end
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge mclk_i);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    rst_n_i = 1'b0;
    oe_seen = 1'b0;
    shadow = '0;
    do_reset();
    t_cfg_rw();
    t_other_ops();
    do_reset();
    tally_and_finish();
  end
endmodule

/* rtl/mdsrp_pkg.sv */
package mdsrp_pkg;
  // frame field lengths, in link clock bits
  localparam int PRE_BITS  = 32;
  localparam int HDR_BITS  = 14;   // start, opcode, phy addr, reg addr
  localparam int DATA_BITS = 16;
  localparam int CNT_W     = 6;
  localparam logic [CNT_W-1:0] PRE_CNT   = 6'h20;
  localparam logic [CNT_W-1:0] HDR_LAST  = 6'h0d;
  localparam logic [CNT_W-1:0] DATA_LAST = 6'h0f;
  // opcode and start codes
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_CFG     = 2'h0;
  localparam logic [1:0] OP_STD_WR  = 2'h1;
  localparam logic [1:0] OP_STD_RD  = 2'h2;
  localparam int PHY_RD_BIT = 4;
  // register space
  localparam int AW = 8;
  localparam int DW = 8;
  localparam logic [AW-1:0] LAST_REG  = 8'h8d;
  localparam int            NUM_REGS  = 142;
  localparam logic [DW-1:0] REG_RST   = 8'h00;
  localparam logic [7:0]    HI_ZERO   = 8'h00;
  // field positions within the 14-bit header shift
  localparam int H_OP_HI = 11;
  localparam int H_OP_LO = 10;
  localparam int H_PHY_HI = 9;
  localparam int H_PHY_LO = 5;

  typedef enum logic [2:0] {
    MDSRP_IDLE = 3'b000,
    MDSRP_PRE  = 3'b001,
    MDSRP_HDR  = 3'b011,
    MDSRP_TA   = 3'b010,
    MDSRP_DATA = 3'b110,
    MDSRP_SKIP = 3'b111
  } mdsrp_state_e;

  // synchronised link pins
  typedef struct packed {
    logic mdc;
    logic mdio;
  } mdsrp_pins_s;

  typedef struct packed {
    mdsrp_state_e      st;
    logic [CNT_W-1:0]  cnt;
    logic [HDR_BITS-1:0] hdr;
    logic [DATA_BITS-1:0] sh;
    logic              rd;
    logic              wr;
    logic [AW-1:0]     addr;
    logic              oe;
    logic              dout;
    logic              we;
    logic [DW-1:0]     wdata;
  } mdsrp_ctl_s;
endpackage

/* rtl/mdsrp_port.sv */
// Summary of operation
// - frame: preamble, start, opcode, addresses, turnaround, data
// - opcode 00, phy msb one: read
// - opcode 00, phy msb zero: write
// - phy address bit three ignored
// - address is phy low three over reg
// - registers 0x00 to 0x8d read/write
// - eight data bits in low byte
// - read returns zero upper byte
// - write ignores upper byte
// - indirect phy registers via config registers
// - otherwise plain clause-22 framing
// - opcodes 10/01 not answered here
module mdsrp_port
  import mdsrp_pkg::*;
(
  // clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  // management link pins
  input  wire logic            mdc_i,
  input  wire logic            mdio_i,
  output logic                 mdio_o,
  output logic                 mdio_oe_o,
  // register file byte view
  output logic [NUM_REGS*DW-1:0] regs_o
);

  // two-stage synchronisers; stage one feeds stage two only
  mdsrp_pins_s s1_reg, s2_reg;
  logic        mdc_d_reg;         // previous synced clock, edge finder
  mdsrp_ctl_s  c_reg, c_next;     // all control state
  logic [DW-1:0] mem_reg [NUM_REGS]; // configuration bytes
  logic        rise;              // one-cycle link rising edge
  logic [DW-1:0] rbyte;           // addressed byte, zero past the map
  logic [AW-1:0] haddr;           // address formed from header
  logic          hdr_ok;          // start code 01 with opcode 00
  logic          hdr_rd;          // header asks for a register read
  logic          hdr_wr;          // header asks for a register write

  // pin synchronisers and edge history; the link is slow next to mclk,
  // so two flops of latency cost nothing and keep a metastable level
  // away from the sequencer
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      mdc_d_reg <= 1'b0;
    end else begin
      s1_reg    <= '{mdc: mdc_i, mdio: mdio_i};
      s2_reg    <= s1_reg;
      mdc_d_reg <= s2_reg.mdc;
    end
  end

  // sample on rising edge only; our drive changes after that edge too
  assign rise = s2_reg.mdc & ~mdc_d_reg;

  // bit three of the phy field is simply left out of the address
  assign haddr = {c_reg.hdr[H_PHY_LO+2:H_PHY_LO], c_reg.hdr[4:0]};

  // header decode; standard opcodes 10/01 and a bad start code
  // leave both selects low, so such frames are only skipped
  assign hdr_ok = (c_reg.hdr[HDR_BITS-1:HDR_BITS-2] == START_CODE)
                && (c_reg.hdr[H_OP_HI:H_OP_LO] == OP_CFG);
  // the phy field msb picks the direction
  assign hdr_rd = hdr_ok && c_reg.hdr[H_PHY_LO+PHY_RD_BIT];
  assign hdr_wr = hdr_ok && !c_reg.hdr[H_PHY_LO+PHY_RD_BIT];

  // unmapped addresses read zero
  always_comb begin
    rbyte = REG_RST;
    if (c_reg.addr <= LAST_REG) begin
      rbyte = mem_reg[c_reg.addr];
    end
  end

  // frame walk, one step per synced link rise:
  //   idle/pre  count ones up to 32, a zero restarts the count
  //   hdr       start bit two, opcode, phy and reg fields (13 bits)
  //   ta        bit one latches the decode and, on reads, takes the
  //             line with a 0; bit two loads the read shift register
  //   data      16 bits msb first; the last rise stores a write and
  //             lets go of the line
  //   skip      same length as data, line left alone
  // limitation: a frame cut short is finished by the next frame's
  // bits, so a controller should close every frame it starts
  // frame sequencer
  always_comb begin
    c_next    = c_reg;
    c_next.we = 1'b0;
    if (rise) begin
      case (c_reg.st)
        // count ones; a zero restarts the preamble
        MDSRP_IDLE, MDSRP_PRE: begin
          c_next.oe = 1'b0;
          if (s2_reg.mdio) begin
            if (c_reg.cnt != PRE_CNT) begin
              c_next.cnt = c_reg.cnt + 1'b1;
            end
            c_next.st = MDSRP_PRE;
          end else if (c_reg.cnt == PRE_CNT) begin
            // first start bit (0) seen after a full preamble
            c_next.st  = MDSRP_HDR;
            c_next.hdr = '0;
            c_next.cnt = CNT_W'(1);
          end else begin
            c_next.cnt = '0;
            c_next.st  = MDSRP_IDLE;
          end
        end
        // shift start bit two, opcode and both address fields
        MDSRP_HDR: begin
          c_next.hdr = {c_reg.hdr[HDR_BITS-2:0], s2_reg.mdio};
          c_next.cnt = c_reg.cnt + 1'b1;
          if (c_reg.cnt == HDR_LAST) begin
            c_next.st  = MDSRP_TA;
            c_next.cnt = '0;
          end
        end
        // decode and run the turnaround
        MDSRP_TA: begin
          if (c_reg.cnt == '0) begin
            // rise of turnaround bit one: latch address and direction
            c_next.addr = haddr;
            c_next.rd   = hdr_rd;
            c_next.wr   = hdr_wr;
            // take the line now so the 0 stands at the second rise
            c_next.oe   = hdr_rd;
            c_next.dout = 1'b0;
            c_next.cnt  = CNT_W'(1);
          end else begin
            // rise of turnaround bit two: put out data bit 15 and keep
            // the rest, msb first, for the following rises
            c_next.dout = HI_ZERO[DW-1];
            c_next.sh   = {HI_ZERO[DW-2:0], rbyte, 1'b0};
            c_next.cnt  = '0;
            c_next.st   = (c_reg.rd || c_reg.wr) ? MDSRP_DATA : MDSRP_SKIP;
          end
        end
        // sixteen data bits, msb first
        MDSRP_DATA: begin
          c_next.cnt  = c_reg.cnt + 1'b1;
          c_next.dout = c_reg.sh[DATA_BITS-1];
          c_next.sh   = {c_reg.sh[DATA_BITS-2:0], s2_reg.mdio};
          if (c_reg.cnt == DATA_LAST) begin
            c_next.st  = MDSRP_IDLE;
            c_next.cnt = '0;
            c_next.oe  = 1'b0;
            // only the low byte is kept, upper byte dropped
            c_next.we    = c_reg.wr && (c_reg.addr <= LAST_REG);
            c_next.wdata = {c_reg.sh[DW-2:0], s2_reg.mdio};
          end
        end
        // frame not for us: wait out the data field with line released
        MDSRP_SKIP: begin
          c_next.oe  = 1'b0;
          c_next.cnt = c_reg.cnt + 1'b1;
          if (c_reg.cnt == DATA_LAST) begin
            c_next.st  = MDSRP_IDLE;
            c_next.cnt = '0;
          end
        end
        default: begin
          c_next = '0;
        end
      endcase
    end
  end

  // control state register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  // configuration byte store; indirect phy access lives behind these
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mem_reg[i] <= REG_RST;
      end
    end else if (c_reg.we) begin
      mem_reg[c_reg.addr] <= c_reg.wdata;
    end
  end

  // flatten the store for the switch core
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_flat
    assign regs_o[g*DW +: DW] = mem_reg[g];
  end

  // the first data bit leaves after the rise that ends turnaround
  assign mdio_o    = c_reg.dout;
  assign mdio_oe_o = c_reg.oe;

  // line only driven from turnaround bit one to the last read bit
  a_oe_only_read: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    mdio_oe_o |-> (c_reg.rd && c_reg.st inside {MDSRP_TA, MDSRP_DATA}))
    else $error("line driven outside read");

  // the first bit we put on the line is the turnaround 0
  a_ta_zero: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(mdio_oe_o) |-> !mdio_o)
    else $error("turnaround bit not zero");

  // the sequencer only moves on a synced link rise
  a_edge_only: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $changed(c_reg.st) |-> $past(rise))
    else $error("state moved without edge");

  // driven read bits change only just after a link rise
  a_drive_step: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (mdio_oe_o && $changed(mdio_o)) |-> $past(rise))
    else $error("read bit moved without edge");

  // a read select needs the configuration opcode
  a_rd_cfg_op: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(c_reg.rd) |-> $past(c_reg.hdr[H_OP_HI:H_OP_LO]) == OP_CFG)
    else $error("read without cfg opcode");

  // a write select needs the phy msb low
  a_wr_phy_msb: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(c_reg.wr) |-> !$past(c_reg.hdr[H_PHY_LO+PHY_RD_BIT]))
    else $error("write with msb set");

  // never both directions at once
  a_rw_excl: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !(c_reg.rd && c_reg.wr))
    else $error("read and write both");

  // a skipped frame never carried the configuration opcode and start
  a_std_op_skip: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(c_reg.st == MDSRP_SKIP) |->
      ($past(c_reg.hdr[H_OP_HI:H_OP_LO]) != OP_CFG)
      || ($past(c_reg.hdr[HDR_BITS-1:HDR_BITS-2]) != START_CODE))
    else $error("config frame skipped");

  // address is phy low bits over the register field, bit three dropped
  a_addr_form: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $changed(c_reg.addr) |-> c_reg.addr ==
      {$past(c_reg.hdr[H_PHY_LO+2:H_PHY_LO]), $past(c_reg.hdr[4:0])})
    else $error("address badly formed");

  // stores only land inside the map
  a_we_range: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    c_reg.we |-> c_reg.addr <= LAST_REG && c_reg.wr)
    else $error("write outside map");

  // unmapped addresses read as zero
  a_unmapped_zero: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (c_reg.addr > LAST_REG) |-> rbyte == REG_RST)
    else $error("unmapped read not zero");

  // the low byte lands where it was addressed
  a_we_store: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    c_reg.we |=> mem_reg[$past(c_reg.addr)] == $past(c_reg.wdata))
    else $error("byte not stored");

  // one store per frame
  a_we_once: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    c_reg.we |=> !c_reg.we)
    else $error("double store");

  // read data opens with zero upper bits
  a_hi_zero: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (c_reg.st == MDSRP_DATA && c_reg.cnt == '0 && c_reg.rd) |->
    c_reg.sh[DATA_BITS-1:DW+1] == HI_ZERO[DW-2:0] && !mdio_o)
    else $error("upper byte not zero");

  // a skipped frame leaves the line alone
  a_skip_quiet: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (c_reg.st == MDSRP_SKIP) |-> !mdio_oe_o)
    else $error("line driven while skipping");

  // the line is let go only at the end of the frame
  a_oe_fall_end: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $fell(mdio_oe_o) |-> c_reg.st == MDSRP_IDLE)
    else $error("line released mid frame");

  // the preamble count saturates at 32
  a_pre_cap: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (c_reg.st == MDSRP_PRE) |-> c_reg.cnt <= PRE_CNT)
    else $error("preamble count overrun");

  // the header starts only after a full preamble
  a_hdr_after_pre: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(c_reg.st == MDSRP_HDR) |-> $past(c_reg.cnt) == PRE_CNT)
    else $error("header without preamble");

  // main scenarios
  c_read:     cover property (@(posedge mclk_i) $rose(mdio_oe_o));
  c_write:    cover property (@(posedge mclk_i) c_reg.we);
  c_skip:     cover property (@(posedge mclk_i) c_reg.st == MDSRP_SKIP);
  c_unmapped: cover property (@(posedge mclk_i)
    c_reg.st == MDSRP_DATA && c_reg.addr > LAST_REG);
endmodule
